// *** dv/adc_serial_readout_port_tb.sv ***
// self-checking bench of the serial readout port
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module adc_serial_readout_port_tb;
  logic clock, rst, lo, hi, fmt, rs_n, frm;
  logic [27:0] filt;
  logic dout, rdy, oe, pdn, spi;
  logic sclk, din;
  wire  pin;
  asrp_pkg::asrp_mode_type mode;
  int failures = 0;
  int total_checks = 0;
  int seed = 91797;
  int m, k;
  logic [23:0] exp_q[$];
  logic [31:0] word;
  realtime t_fall, t_prev;

  // shared pin: device drives while enabled, bench otherwise
  assign pin = oe ? rdy : frm;

  asrp_port uut (.clock(clock), .rst(rst), .mode_low_det(lo), .mode_high_det(hi), .format_pin(fmt),
    .resync_powerdown_n(rs_n), .sclk(sclk), .din(din), .ready_or_frame_in(pin), .filter_value(filt),
    .dout(dout), .ready_or_frame_out(rdy), .ready_or_frame_oe(oe), .powered_down(pdn),
    .op_mode(mode), .spi_format(spi));

  asrp_host host_i (.sclk(sclk), .din(din), .ready_n(pin), .dout(dout));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(negedge rdy)
  begin
    t_prev = t_fall;
    t_fall = $realtime;
  end

  function automatic logic [23:0] clamp(input logic [27:0] v);
    int s;
    begin
      s = $signed(v);
      if (s > 8388607)
        return 24'h7FFFFF;
      if (s < -8388608)
        return 24'h800000;
      return v[23:0];
    end
  endfunction

  task automatic finish_test;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task automatic pulse;
    begin
      rs_n = 1'b0;
      repeat (4) @(negedge clock);
      rs_n = 1'b1;
      repeat (4) @(negedge clock);
    end
  endtask

  // one read; the word set here is loaded at the next period end
  task automatic xfer(input int n, input logic [27:0] nxt, input int per);
    logic [7:0] ch;
    logic [23:0] ex;
    begin
      ch = 8'($random(seed));
      host_i.read(n, 1'b1, ch, word);
      `CHK("ready_high", 1'b1, rdy)
      if (per > 0)
        `CHK("period", per, int'((t_fall - t_prev) / 40.0))
      if (exp_q.size() > 0)
      begin
        ex = exp_q.pop_front();
        `CHK("result", ex, word[n-1 -: 24])
      end
      if (n == 28)
        `CHK("chain", ch[7:4], word[3:0])
      @(negedge clock);
      filt = nxt;
      exp_q.push_back(clamp(nxt));
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    {lo, hi, fmt, frm, rst, rs_n} = 6'h03;
    filt = 28'h0123456;
    repeat (8) @(negedge clock);
    `CHK("rst_dout", 1'b0, dout)
    `CHK("rst_ready", 1'b1, rdy)
    `CHK("rst_pdn", 1'b0, pdn)
    rst = 1'b0;
    for (m = 0; m < 4; m++)
    begin
      lo = m[0];
      hi = m[1];
      pulse();
      `CHK("resync_ready", 1'b1, rdy)
      `CHK("mode", m[0] ? asrp_pkg::ASRP_FAST : m[1] ? asrp_pkg::ASRP_LOWPWR : asrp_pkg::ASRP_FINE, mode)
      `CHK("spi", 1'b1, spi)
      `CHK("oe", 1'b1, oe)
      exp_q.delete();
      for (k = 0; k < 6; k++)
        xfer(m[0] ? 24 : 28, k == 1 ? 28'h07FFFFF : k == 2 ? 28'hF800000 : k == 3 ? 28'h0800000 :
             k == 4 ? 28'hF7FFFFF : 28'($random(seed)), k > 0 ? (m[0] ? 256 : 512) : 0);
    end
    rs_n = 1'b0;
    repeat (530) @(negedge clock);
    `CHK("pdn_on", 1'b1, pdn)
    `CHK("pdn_ready", 1'b1, rdy)
    rs_n = 1'b1;
    repeat (4) @(negedge clock);
    `CHK("pdn_off", 1'b0, pdn)
    fmt = 1'b1;
    filt = 28'h0ABCDEF;
    repeat (4) @(negedge clock);
    `CHK("fs_oe", 1'b0, oe)
    `CHK("fs_spi", 1'b0, spi)
    frm = 1'b1;
    repeat (8) @(negedge clock);
    frm = 1'b0;
    repeat (4) @(negedge clock);
    host_i.read(24, 1'b0, 8'h00, word);
    `CHK("fs_result", clamp(28'h0ABCDEF), word[23:0])
    finish_test();
  end

  initial
  begin
    #2000000;
    failures++;
    finish_test();
  end
endmodule

// *** dv/asrp_host.sv ***
// host model that clocks results out of the readout port
`timescale 1ns/1ps

module asrp_host (
  output logic      sclk,     // serial clock to device
  output logic      din,      // chain data into device
  input  wire logic ready_n,  // shared ready pin level
  input  wire logic dout      // serial data from device
);
  initial
  begin
    sclk = 1'b0;
    din  = 1'b0;
  end

  // sclk stands low between frames; din toggles once released
  task automatic read(input int n, input bit wait_rdy, input logic [7:0] ch, output logic [31:0] w);
    int i;
    begin
      w = 32'h0;
      // ready falls on a rising clock edge; step half a clock to a falling one
      if (wait_rdy)
      begin
        wait (ready_n === 1'b0);
        #20;
      end
      for (i = 0; i < n; i++)
      begin
        #160 sclk = 1'b1;
        w = {w[30:0], dout};
        din = (i < 8) ? ch[7-i] : ~din;
        #160 sclk = 1'b0;
      end
      #160 din = ~din;
    end
  endtask
endmodule

// *** rtl/asrp_defs.svh ***
// constants of the converter serial readout port
//
// Operation
// - mode pin: low fast, float fine, high low-power
// - format pin low SPI, high frame-sync
// - shared pin drives ready or takes frame
// - resync/power-down input is active low
// - daisy-chain input shifts behind own result
// - result every 256 or 512 master clocks
// - ready output falls when result is ready
// - first bit valid before ready falls
// - ready returns high after serial clock falls
// - next bit shifted out on serial falling edge
// - chain input sampled on serial falling edges
// - 24-bit two's complement result, saturating
`ifndef ASRP_DEFS_SVH
`define ASRP_DEFS_SVH

`define ASRP_RES_W        24
`define ASRP_FILT_W       28
`define ASRP_SYNC_W       7
`define ASRP_CNT_W        10
`define ASRP_CONV_FAST    10'h100
`define ASRP_CONV_SLOW    10'h200
`define ASRP_PDWN_HOLD    10'h200
`define ASRP_POS_FS       24'h7FFFFF
`define ASRP_NEG_FS       24'h800000
`define ASRP_POS_FS_WIDE  28'h07FFFFF
`define ASRP_NEG_FS_WIDE  28'hF800000
`define ASRP_SHREG_RST    24'h000000
`define ASRP_CNT_RST      10'h000

`endif

// *** rtl/asrp_pkg.sv ***
// types of the converter serial readout port
package asrp_pkg;

  typedef enum logic [1:0] {
    ASRP_FAST,
    ASRP_FINE,
    ASRP_LOWPWR
  } asrp_mode_type;

  typedef struct packed {
    logic [9:0]  conv_cnt;
    logic [9:0]  hold_cnt;
    logic        pd;
    logic        result_ready_n;
    logic        armed;
    logic        load_p;
    logic [23:0] shreg;
    logic        sclk_p;
    logic        frame_p;
  } asrp_state_type;

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
  } asrp_sync_state_type;

endpackage

// *** rtl/asrp_port.sv ***
// serial readout port of a 24-bit converter
`timescale 1ns/1ps
`include "asrp_defs.svh"

module asrp_port (
  input  wire logic                    clock,               // master clock, 25 MHz
  input  wire logic                    rst,                 // synchronous reset, active high
  input  wire logic                    mode_low_det,        // mode pin seen driven low
  input  wire logic                    mode_high_det,       // mode pin seen driven high
  input  wire logic                    format_pin,          // 0 SPI, 1 frame-sync
  input  wire logic                    resync_powerdown_n,  // resync / power-down, active low
  input  wire logic                    sclk,                // serial clock from host
  input  wire logic                    din,                 // daisy-chain data input
  input  wire logic                    ready_or_frame_in,   // shared pin, input side
  input  wire logic [`ASRP_FILT_W-1:0] filter_value,        // signed filter output, same clock
  output logic                         dout,                // serial data output
  output logic                         ready_or_frame_out,  // shared pin, output side
  output logic                         ready_or_frame_oe,   // shared pin, drive enable
  output logic                         powered_down,        // converter halted
  output asrp_pkg::asrp_mode_type      op_mode,             // decoded operating mode
  output logic                         spi_format           // SPI readout selected
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [`ASRP_SYNC_W-1:0] pins_s;
  logic                    mode_low_s;
  logic                    mode_high_s;
  logic                    format_s;
  logic                    sync_n_s;
  logic                    sclk_s;
  logic                    din_s;
  logic                    frame_strobe_in;

  // sclk and din share the same latency, so din lines up with the detected edge
  asrp_sync u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({mode_low_det, mode_high_det, format_pin, resync_powerdown_n,
             sclk, din, ready_or_frame_in}),
    .q     (pins_s)
  );

  assign mode_low_s      = pins_s[6];
  assign mode_high_s     = pins_s[5];
  assign format_s        = pins_s[4];
  assign sync_n_s        = pins_s[3];
  assign sclk_s          = pins_s[2];
  assign din_s           = pins_s[1];
  assign frame_strobe_in = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////////
  // functions

  // clamp the wide filter word to the 24-bit code range
  function automatic logic [`ASRP_RES_W-1:0] asrp_sat(input logic [`ASRP_FILT_W-1:0] v);
    logic [`ASRP_RES_W-1:0] r;
    r = v[`ASRP_RES_W-1:0];
    if ($signed(v) > $signed(`ASRP_POS_FS_WIDE))
    begin
      r = `ASRP_POS_FS;
    end
    else if ($signed(v) < $signed(`ASRP_NEG_FS_WIDE))
    begin
      r = `ASRP_NEG_FS;
    end
    return r;
  endfunction

  // last count of a conversion period for a mode
  function automatic logic [`ASRP_CNT_W-1:0] asrp_last(input asrp_pkg::asrp_mode_type m);
    logic [`ASRP_CNT_W-1:0] p;
    p = (m == asrp_pkg::ASRP_FAST) ? `ASRP_CONV_FAST : `ASRP_CONV_SLOW;
    return p - 10'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // mode and format decode

  always_comb
  begin
    if (mode_low_s)
    begin
      op_mode = asrp_pkg::ASRP_FAST;
    end
    else if (mode_high_s)
    begin
      op_mode = asrp_pkg::ASRP_LOWPWR;
    end
    else
    begin
      op_mode = asrp_pkg::ASRP_FINE;
    end
  end

  assign spi_format = ~format_s;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  asrp_pkg::asrp_state_type q;
  asrp_pkg::asrp_state_type n;

  logic sclk_rise;
  logic sclk_fall;
  logic frame_rise;
  logic period_end;

  assign sclk_rise  = ~q.sclk_p & sclk_s;
  assign sclk_fall  = q.sclk_p & ~sclk_s;
  assign frame_rise = ~q.frame_p & frame_strobe_in;
  assign period_end = (q.conv_cnt >= asrp_last(op_mode));

  always_comb
  begin
    n         = q;
    n.sclk_p  = sclk_s;
    n.frame_p = frame_strobe_in;
    n.load_p  = 1'b0;
    if (!sync_n_s)
    begin
      // low restarts the period; held low long enough it halts the converter
      n.conv_cnt       = `ASRP_CNT_RST;
      n.result_ready_n = 1'b1;
      n.armed          = 1'b0;
      if (q.hold_cnt != `ASRP_PDWN_HOLD)
      begin
        n.hold_cnt = q.hold_cnt + 10'h001;
      end
      else
      begin
        n.pd = 1'b1;
      end
    end
    else
    begin
      n.hold_cnt = `ASRP_CNT_RST;
      n.pd       = 1'b0;
      if (period_end)
      begin
        n.conv_cnt = `ASRP_CNT_RST;
      end
      else
      begin
        n.conv_cnt = q.conv_cnt + 10'h001;
      end
      if (spi_format && !q.result_ready_n && sclk_rise)
      begin
        n.armed = 1'b1;
      end
      if (sclk_fall)
      begin
        n.shreg = {q.shreg[`ASRP_RES_W-2:0], din_s};
        if (q.armed)
        begin
          n.result_ready_n = 1'b1;
          n.armed          = 1'b0;
        end
      end
      // ready falls one clock after the word is loaded, so the MSB leads it;
      // it comes after the release so that an old read never hides a new word
      if (q.load_p)
      begin
        n.result_ready_n = 1'b0;
        n.armed          = 1'b0;
      end
      // an unread word is overwritten by the next one
      if (spi_format && period_end)
      begin
        n.shreg  = asrp_sat(filter_value);
        n.load_p = 1'b1;
      end
      else if (!spi_format && frame_rise)
      begin
        n.shreg = asrp_sat(filter_value);
      end
      if (!spi_format)
      begin
        n.result_ready_n = 1'b1;
        n.armed          = 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      q.conv_cnt       <= `ASRP_CNT_RST;
      q.hold_cnt       <= `ASRP_CNT_RST;
      q.pd             <= 1'b0;
      q.result_ready_n <= 1'b1;
      q.armed          <= 1'b0;
      q.load_p         <= 1'b0;
      q.shreg          <= `ASRP_SHREG_RST;
      q.sclk_p         <= 1'b0;
      q.frame_p        <= 1'b0;
    end
    else
    begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign dout               = q.shreg[`ASRP_RES_W-1];
  assign ready_or_frame_out = q.result_ready_n;
  // in frame-sync format the pin is released to the host's frame strobe
  assign ready_or_frame_oe  = spi_format;
  assign powered_down       = q.pd;

  // bit that the next serial falling edge brings to dout
  logic next_bit;
  assign next_bit = q.shreg[`ASRP_RES_W-2];

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_load;
    q.load_p && sync_n_s;
  endsequence

  sequence s_ready_fall;
    $fell(q.result_ready_n);
  endsequence

  AST_MODE_DECODE: assert property (
    @(posedge clock) disable iff (rst)
    (mode_low_s |-> op_mode == asrp_pkg::ASRP_FAST) and
    ((!mode_low_s && !mode_high_s) |-> op_mode == asrp_pkg::ASRP_FINE))
    else $error("mode pin decoded wrongly");

  AST_PIN_DIR: assert property (
    @(posedge clock) disable iff (rst)
    format_s |-> !ready_or_frame_oe ##1 q.result_ready_n)
    else $error("shared pin driven in frame-sync format");

  AST_RESYNC_STOPS: assert property (
    @(posedge clock) disable iff (rst)
    !sync_n_s |=> q.conv_cnt == `ASRP_CNT_RST && q.result_ready_n)
    else $error("resync low did not restart the period");

  AST_PERIOD_FAST: assert property (
    @(posedge clock) disable iff (rst)
    (op_mode == asrp_pkg::ASRP_FAST && $stable(op_mode)) |-> q.conv_cnt < `ASRP_CONV_FAST)
    else $error("fast mode period longer than 256 clocks");

  AST_LOAD_AT_END: assert property (
    @(posedge clock) disable iff (rst)
    (period_end && sync_n_s && spi_format) |=> q.load_p && q.conv_cnt == `ASRP_CNT_RST)
    else $error("no result at the end of a conversion period");

  AST_READY_FALLS: assert property (
    @(posedge clock) disable iff (rst)
    s_load ##1 sync_n_s |-> !q.result_ready_n)
    else $error("ready did not fall after a new result");

  AST_MSB_LEADS: assert property (
    @(posedge clock) disable iff (rst)
    s_ready_fall |-> $past(q.load_p) && dout == $past(dout))
    else $error("ready fell without the first bit in place");

  AST_READY_RISE: assert property (
    @(posedge clock) disable iff (rst)
    ($rose(q.result_ready_n) && $past(sync_n_s) && $past(spi_format)) |-> $past(sclk_fall))
    else $error("ready returned high without a serial falling edge");

  AST_CHAIN_SHIFT: assert property (
    @(posedge clock) disable iff (rst)
    (sclk_fall && sync_n_s && !period_end && !frame_rise) |=> q.shreg[0] == $past(din_s))
    else $error("chain input not shifted in on a falling edge");

  AST_SATURATE: assert property (
    @(posedge clock) disable iff (rst)
    s_load |-> (($signed($past(filter_value)) > $signed(`ASRP_POS_FS_WIDE)) ? q.shreg == `ASRP_POS_FS :
                ($signed($past(filter_value)) < $signed(`ASRP_NEG_FS_WIDE)) ? q.shreg == `ASRP_NEG_FS :
                {{4{q.shreg[`ASRP_RES_W-1]}}, q.shreg} == $past(filter_value)))
    else $error("loaded result not clamped to code range");

  AST_SHIFT_OUT: assert property (
    @(posedge clock) disable iff (rst)
    (sclk_fall && sync_n_s && !(spi_format ? period_end : frame_rise)) |=> dout == $past(next_bit))
    else $error("next bit not shifted out on a serial falling edge");

  AST_PDWN_ENTRY: assert property (
    @(posedge clock) disable iff (rst)
    (!sync_n_s && q.hold_cnt == `ASRP_PDWN_HOLD) |=> powered_down)
    else $error("held resync low did not power down");

  AST_PDWN_EXIT: assert property (
    @(posedge clock) disable iff (rst)
    sync_n_s |=> !powered_down)
    else $error("power-down not left on resync release");

  AST_READY_HOLDS: assert property (
    @(posedge clock) disable iff (rst)
    (!q.result_ready_n && sync_n_s && spi_format && !sclk_fall) |=> !ready_or_frame_out)
    else $error("ready rose without a serial falling edge");

  AST_ARM_AFTER_READY: assert property (
    @(posedge clock) disable iff (rst)
    q.armed |-> !q.result_ready_n)
    else $error("read armed while no result was ready");

endmodule

// *** rtl/asrp_sync.sv ***
// two-flop synchroniser for the pins of the readout port
`timescale 1ns/1ps
`include "asrp_defs.svh"

module asrp_sync (
  input  wire logic                    clock,  // master clock
  input  wire logic                    rst,    // synchronous reset
  input  wire logic [`ASRP_SYNC_W-1:0] d,      // raw pin levels
  output logic      [`ASRP_SYNC_W-1:0] q       // levels after two flops
);

  asrp_pkg::asrp_sync_state_type st_q;
  asrp_pkg::asrp_sync_state_type st_d;

  // first stage is read only by the second stage
  always_comb
  begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule
